// ---- logic/lcs_regs.svh ----
/*
 * Register map, field positions, reset values and timing figures of the
 * light conversion control and status block.
 * Assumes a 50 MHz clock and 32-bit AXI4-Lite data.
 */
`ifndef LCS_REGS_SVH
`define LCS_REGS_SVH

`define CFG_OFS       8'h00
`define HLIM_OFS      8'h04
`define RES_OFS       8'h08
`define ISTAT_OFS     8'h0C
`define IMASK_OFS     8'h10

`define CFG_RESET     16'hC810
`define HLIM_RESET    16'hBFFF

`define F_RANGE_LO    12
`define F_CT          11
`define F_MODE_LO     9
`define F_LATCH       4
`define F_POL         3
`define F_ME          2
`define F_FC_LO       0

`define RANGE_AUTO    4'hC
`define RANGE_MAX     4'hB
`define RANGE_MIN     4'h0
`define RANGE_LOSE1   4'h5
`define MODE_SHUT     2'h0
`define MODE_SINGLE   2'h1

`define IRQ_DONE      0
`define IRQ_OVF       1
`define IRQ_ABOVE     2

`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`define CLK_HZ        50000000
`define SHORT_MS      100
`define LONG_MS       800
`define MS_TO_CYC(ms) ((ms) * (`CLK_HZ / 1000))

`endif

// ---- logic/lcs_pkg.sv ----
/*
 * Types shared by the light conversion control and status block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package lcs_pkg;
    typedef enum logic {CV_IDLE, CV_INTEG} conv_state_e;
    typedef logic [3:0] range_t;
    typedef logic [1:0] mode_t;
endpackage

// ---- logic/integ_timer.sv ----
/*
 * Integration timer: counts one integration period, can be aborted.
 * Assumes start and abort are one-cycle pulses on clk.
 */
`timescale 1ns/1ps
`default_nettype none
module integ_timer #(
    parameter int W = 26
) (
    input  wire logic         clk,    // system clock
    input  wire logic         resetn, // async reset, active low
    input  wire logic         start,  // begin a period
    input  wire logic         abort,  // drop the running period
    input  wire logic [W-1:0] len,    // period in cycles
    output logic              busy,   // period running
    output logic              done    // period ended, one cycle
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         busy;
        logic         done;
    } tmr_s;

    tmr_s s_ff, nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        if (abort) begin
            nxt_s.busy = 1'b0;
        end else if (start) begin
            nxt_s.busy = 1'b1;
            nxt_s.cnt  = len - W'(1);
        end else if (s_ff.busy) begin
            if (s_ff.cnt == '0) begin
                nxt_s.busy = 1'b0;
                nxt_s.done = 1'b1;
            end else begin
                nxt_s.cnt = s_ff.cnt - W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign busy = s_ff.busy;
    assign done = s_ff.done;
endmodule
`default_nettype wire

// ---- logic/fault_streak.sv ----
/*
 * Consecutive fault counter: pulses hit when enough results in a row exceed.
 * Assumes sample is a one-cycle pulse per finished measurement.
 */
`timescale 1ns/1ps
`default_nettype none
module fault_streak (
    input  wire logic       clk,    // system clock
    input  wire logic       resetn, // async reset, active low
    input  wire logic       clear,  // restart the streak
    input  wire logic       sample, // a measurement finished
    input  wire logic       exceed, // that measurement was a fault
    input  wire logic [3:0] need,   // faults in a row required
    output logic            hit     // streak reached, one cycle
);
    typedef struct packed {
        logic [3:0] cnt;
        logic       hit;
    } streak_s;

    streak_s s_ff, nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.hit = 1'b0;
        if (clear) begin
            nxt_s.cnt = '0;
        end else if (sample && !exceed) begin
            nxt_s.cnt = '0;
        end else if (sample) begin
            if (s_ff.cnt + 4'h1 >= need) begin
                nxt_s.hit = 1'b1;
                nxt_s.cnt = need;
            end else begin
                nxt_s.cnt = s_ff.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign hit = s_ff.hit;
endmodule
`default_nettype wire

// ---- logic/light_conv_ctrl.sv ----
/*
 * Conversion control and status of an ambient light sensor, reached over
 * AXI4-Lite: integration length, operating mode, automatic range stepping,
 * overrange / done / above-limit flags and a masked interrupt.
 * Assumes the converter front end integrates while integrating is high and
 * presents its code and an overload level when integrating falls.
 */
// Function
// (RULE1) integration select: 0 is 100 ms, 1 is 800 ms
// (RULE2) short integration drops low result bits
// (RULE3) result format unchanged by integration length
// (RULE4) mode 00 shutdown, 01 single, 1x continuous
// (RULE5) single shot returns mode to shutdown
// (RULE6) shutdown keeps flags and interrupt
// (RULE7) overrange reflects each measurement's overflow
// (RULE8) manual range flags transient overloads
// (RULE9) auto range flags overrange only at top
// (RULE10) auto range aborts, steps up, retries
// (RULE11) overrange updated after retries finish
// (RULE12) done flag set at conversion end
// (RULE13) config access clears done, except shutdown write
// (RULE14) above flag after enough faults over limit
// (RULE15) config write aborts, maybe restarts conversion
// (RULE16) range code 1100 selects automatic range
// (RULE17) fault count codes need 1,2,4,8
`timescale 1ns/1ps
`default_nettype none
`include "lcs_regs.svh"
module light_conv_ctrl #(
    parameter int SHORT_CYCLES = `MS_TO_CYC(`SHORT_MS),
    parameter int LONG_CYCLES  = `MS_TO_CYC(`LONG_MS),
    parameter int TW           = 26
) (
    input  wire logic          clk,           // 50 MHz clock
    input  wire logic          resetn,        // async reset, active low
    input  wire logic [7:0]    awaddr,        // write address
    input  wire logic          awvalid,       // write address valid
    output logic               awready,       // write address ready
    input  wire logic [31:0]   wdata,         // write data
    input  wire logic [3:0]    wstrb,         // write byte strobes
    input  wire logic          wvalid,        // write data valid
    output logic               wready,        // write data ready
    output logic [1:0]         bresp,         // write response
    output logic               bvalid,        // write response valid
    input  wire logic          bready,        // write response ready
    input  wire logic [7:0]    araddr,        // read address
    input  wire logic          arvalid,       // read address valid
    output logic               arready,       // read address ready
    output logic [31:0]        rdata,         // read data
    output logic [1:0]         rresp,         // read response
    output logic               rvalid,        // read data valid
    input  wire logic          rready,        // read data ready
    output logic               integrating,   // front end integrating
    output logic               integ_reset,   // clear integrator, pulse
    output lcs_pkg::range_t    conv_range,    // range in use
    input  wire logic [11:0]   adc_code,      // converted code
    input  wire logic          adc_overload,  // overload seen in period
    output logic               irq            // level interrupt
);
    import lcs_pkg::*;

    typedef struct packed {
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        range_t      range_sel;
        logic        ct;
        mode_t       mode;
        logic        ovf;
        logic        done;
        logic        above;
        logic        latch;
        logic        pol;
        logic        me;
        logic [1:0]  fc;
        logic [15:0] hlim;
        logic [15:0] result;
        logic [2:0]  istat;
        logic [2:0]  imask;
        conv_state_e cstate;
        range_t      cur_range;
        logic        start;
        logic        abort;
    } ctrl_s;

    ctrl_s s_ff, nxt_s;

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  st);
        merge = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == `CFG_OFS) || (a == `HLIM_OFS) || (a == `RES_OFS)
              || (a == `ISTAT_OFS) || (a == `IMASK_OFS);
    endfunction

    // bits of lost resolution at short integration
    function automatic logic [11:0] res_mask(input range_t r, input logic ct);
        logic [1:0] lost;
        lost = 2'h0;
        if (!ct && r == `RANGE_LOSE1) begin
            lost = 2'h1;
        end else if (!ct && r < `RANGE_LOSE1 && r != `RANGE_MIN) begin
            lost = 2'h2;
        end else if (!ct && r == `RANGE_MIN) begin
            lost = 2'h3;
        end
        res_mask = 12'hFFF << lost;
    endfunction

    function automatic logic [26:0] to_lux(input logic [15:0] v);
        to_lux = 27'(v[11:0]) << v[15:12];
    endfunction

    logic        aw_hs, w_hs, ar_hs, wr_go, wr_cfg;
    logic        auto_rng, tmr_busy, tmr_done, finish, retry, hit, exceed;
    logic [7:0]  ra, wa;
    logic [11:0] code_m;
    logic [15:0] cfg_word, new_cfg;
    logic [TW-1:0] tmr_len;

    assign awready = !s_ff.aw_got && !s_ff.bvalid;
    assign wready  = !s_ff.w_got && !s_ff.bvalid;
    assign arready = !s_ff.rvalid;
    assign aw_hs   = awvalid && awready;
    assign w_hs    = wvalid && wready;
    assign ar_hs   = arvalid && arready;
    assign ra      = {araddr[7:2], 2'b00};
    assign wa      = {s_ff.aw_addr[7:2], 2'b00};
    assign wr_go   = s_ff.aw_got && s_ff.w_got && !s_ff.bvalid;
    assign wr_cfg  = wr_go && wa == `CFG_OFS;
    assign new_cfg = merge(cfg_word, s_ff.w_data, s_ff.w_strb);

    assign cfg_word = {s_ff.range_sel, s_ff.ct, s_ff.mode, s_ff.ovf, s_ff.done,
                       s_ff.above, 1'b0, s_ff.latch, s_ff.pol, s_ff.me, s_ff.fc};

    assign auto_rng = s_ff.range_sel == `RANGE_AUTO; // [RULE16]
    assign tmr_len  = s_ff.ct ? TW'(LONG_CYCLES) : TW'(SHORT_CYCLES); // [RULE1]
    // resolution loss keeps the same word format and weight
    assign code_m   = adc_code & res_mask(s_ff.cur_range, s_ff.ct); // [RULE2] [RULE3]
    assign exceed   = to_lux({s_ff.cur_range, code_m}) > to_lux(s_ff.hlim); // [RULE14]
    // overflow below top range in auto mode means step up and retry
    // a done pulse in the cycle after a config write belongs to the dropped period
    assign retry    = s_ff.cstate == CV_INTEG && tmr_done && auto_rng && adc_overload
                      && s_ff.cur_range < `RANGE_MAX && !s_ff.abort; // [RULE10]
    assign finish   = s_ff.cstate == CV_INTEG && tmr_done && !retry && !s_ff.abort;

    integ_timer #(.W(TW)) u_timer (
        .clk    (clk),
        .resetn (resetn),
        .start  (s_ff.start),
        .abort  (s_ff.abort),
        .len    (tmr_len),
        .busy   (tmr_busy),
        .done   (tmr_done)
    );

    fault_streak u_streak (
        .clk    (clk),
        .resetn (resetn),
        .clear  (wr_cfg),
        .sample (finish),
        .exceed (exceed),
        .need   (4'h1 << s_ff.fc), // [RULE17]
        .hit    (hit)
    );

    always_comb begin
        nxt_s = s_ff;
        nxt_s.start = 1'b0;
        nxt_s.abort = 1'b0;
        if (aw_hs) begin
            nxt_s.aw_got  = 1'b1;
            nxt_s.aw_addr = awaddr;
        end
        if (w_hs) begin
            nxt_s.w_got  = 1'b1;
            nxt_s.w_data = wdata;
            nxt_s.w_strb = wstrb;
        end
        if (s_ff.bvalid && bready) begin
            nxt_s.bvalid = 1'b0;
        end
        if (s_ff.rvalid && rready) begin
            nxt_s.rvalid = 1'b0;
        end
        if (ar_hs) begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rresp  = mapped(ra) ? `RESP_OKAY : `RESP_SLVERR;
            nxt_s.rdata  = '0;
            unique case (ra)
                `CFG_OFS: begin
                    nxt_s.rdata = {16'h0000, cfg_word};
                    nxt_s.done  = 1'b0; // [RULE13]
                    if (s_ff.latch) begin
                        nxt_s.above = 1'b0;
                    end
                end
                `HLIM_OFS:  nxt_s.rdata = {16'h0000, s_ff.hlim};
                `RES_OFS:   nxt_s.rdata = {16'h0000, s_ff.result};
                `ISTAT_OFS: nxt_s.rdata = {29'h0, s_ff.istat};
                `IMASK_OFS: nxt_s.rdata = {29'h0, s_ff.imask};
                default:    nxt_s.rdata = '0;
            endcase
        end
        if (wr_go) begin
            nxt_s.aw_got = 1'b0;
            nxt_s.w_got  = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp  = mapped(wa) ? `RESP_OKAY : `RESP_SLVERR;
            if (wa == `HLIM_OFS) begin
                nxt_s.hlim = merge(s_ff.hlim, s_ff.w_data, s_ff.w_strb);
            end
            if (wa == `IMASK_OFS && s_ff.w_strb[0]) begin
                nxt_s.imask = s_ff.w_data[2:0];
            end
            if (wa == `ISTAT_OFS && s_ff.w_strb[0]) begin
                nxt_s.istat = s_ff.istat & ~s_ff.w_data[2:0];
            end
            if (wr_cfg && new_cfg[`F_MODE_LO+:2] != `MODE_SHUT) begin
                nxt_s.done = 1'b0; // [RULE13]
            end
        end
        if (retry) begin
            // overrange stays as it was until the retries settle
            nxt_s.start     = 1'b1; // [RULE11]
            nxt_s.cur_range = s_ff.cur_range + 4'h1; // [RULE10]
        end
        if (finish) begin
            nxt_s.ovf    = adc_overload; // [RULE7] [RULE8] [RULE9]
            nxt_s.result = {(s_ff.me && !auto_rng) ? 4'h0 : s_ff.cur_range, code_m};
            nxt_s.done   = 1'b1; // [RULE12]
            nxt_s.istat[`IRQ_DONE] = 1'b1;
            if (adc_overload) begin
                nxt_s.istat[`IRQ_OVF] = 1'b1;
            end
            if (!exceed && !s_ff.latch) begin
                nxt_s.above = 1'b0;
            end
            if (s_ff.mode == `MODE_SINGLE) begin
                nxt_s.mode   = `MODE_SHUT; // [RULE5]
                nxt_s.cstate = CV_IDLE;
            end else begin
                nxt_s.start     = 1'b1; // [RULE4]
                nxt_s.cur_range = auto_rng ? `RANGE_MIN : s_ff.range_sel;
            end
        end
        if (hit) begin
            nxt_s.above = 1'b1; // [RULE14]
            nxt_s.istat[`IRQ_ABOVE] = 1'b1;
        end
        if (s_ff.abort && s_ff.cstate == CV_INTEG) begin
            // timer drops the old period first, the new one starts a cycle later
            nxt_s.start = 1'b1; // [RULE15]
        end
        if (wr_cfg) begin
            // a shutdown write leaves every flag as it stands
            nxt_s.range_sel = new_cfg[`F_RANGE_LO+:4]; // [RULE6]
            nxt_s.ct        = new_cfg[`F_CT];
            nxt_s.mode      = new_cfg[`F_MODE_LO+:2];
            nxt_s.latch     = new_cfg[`F_LATCH];
            nxt_s.pol       = new_cfg[`F_POL];
            nxt_s.me        = new_cfg[`F_ME];
            nxt_s.fc        = new_cfg[`F_FC_LO+:2];
            nxt_s.abort     = 1'b1; // [RULE15]
            nxt_s.start     = 1'b0;
            nxt_s.cstate    = CV_IDLE;
            if (new_cfg[`F_MODE_LO+:2] != `MODE_SHUT) begin
                nxt_s.cstate    = CV_INTEG;
                nxt_s.cur_range = new_cfg[`F_RANGE_LO+:4] == `RANGE_AUTO ?
                                  `RANGE_MIN : new_cfg[`F_RANGE_LO+:4];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_ff           <= '0;
            s_ff.range_sel <= 4'(`CFG_RESET >> `F_RANGE_LO);
            s_ff.ct        <= 1'(`CFG_RESET >> `F_CT);
            s_ff.latch     <= 1'(`CFG_RESET >> `F_LATCH);
            s_ff.hlim      <= `HLIM_RESET;
            s_ff.cstate    <= CV_IDLE;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign bvalid      = s_ff.bvalid;
    assign bresp       = s_ff.bresp;
    assign rvalid      = s_ff.rvalid;
    assign rdata       = s_ff.rdata;
    assign rresp       = s_ff.rresp;
    assign integrating = tmr_busy;
    assign integ_reset = s_ff.start;
    assign conv_range  = s_ff.cur_range;
    assign irq         = |(s_ff.istat & s_ff.imask); // [RULE6]

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    a_timer_length: assert property ( // [RULE1]
        s_ff.start && !s_ff.abort |=> tmr_busy && u_timer.s_ff.cnt == tmr_len - TW'(1))
        else $error("integration length does not follow select bit");
    a_lost_bits: assert property ( // [RULE2]
        finish && !s_ff.ct && s_ff.cur_range == `RANGE_MIN && !(s_ff.me && !auto_rng)
        |=> s_ff.result[2:0] == 3'h0)
        else $error("short integration kept bits it cannot resolve");
    a_single_end: assert property ( // [RULE5]
        finish && s_ff.mode == `MODE_SINGLE && !wr_cfg
        |=> s_ff.mode == `MODE_SHUT && s_ff.cstate == CV_IDLE ##1 !tmr_busy)
        else $error("single shot did not return to shutdown");
    a_shut_keeps: assert property ( // [RULE6]
        wr_cfg && new_cfg[`F_MODE_LO+:2] == `MODE_SHUT && !finish && !ar_hs && !hit
        |=> s_ff.done == $past(s_ff.done) && s_ff.istat == $past(s_ff.istat))
        else $error("shutdown write disturbed flags");
    a_ovf_value: assert property ( // [RULE7]
        finish |=> s_ff.ovf == $past(adc_overload))
        else $error("overrange does not follow measurement");
    a_auto_top: assert property ( // [RULE9]
        finish && auto_rng && adc_overload |-> s_ff.cur_range == `RANGE_MAX)
        else $error("auto range flagged overrange below top range");
    a_retry_step: assert property ( // [RULE10]
        retry && !wr_cfg |=> s_ff.cur_range == $past(s_ff.cur_range) + 4'h1
        && s_ff.ovf == $past(s_ff.ovf) ##1 tmr_busy)
        else $error("auto range did not step up and retry");
    a_done_set: assert property ( // [RULE12]
        finish |=> s_ff.done && s_ff.istat[`IRQ_DONE])
        else $error("done flag not set at conversion end");
    a_done_rdclr: assert property ( // [RULE13]
        ar_hs && ra == `CFG_OFS && !finish |=> !s_ff.done)
        else $error("config read did not clear done");
    a_above_hit: assert property ( // [RULE14]
        finish && exceed && s_ff.fc == 2'h0 && !wr_cfg |=> ##1 s_ff.above)
        else $error("above flag missing after fault");
    a_write_abort: assert property ( // [RULE15]
        wr_cfg |=> s_ff.abort ##1 !tmr_busy ##1 (tmr_busy == (s_ff.cstate == CV_INTEG)))
        else $error("config write did not abort conversion");

    c_single_shot: cover property (finish && s_ff.mode == `MODE_SINGLE);
    c_auto_retry: cover property (retry ##[1:1000] finish);
    c_above_flag: cover property (hit);
    c_irq_raised: cover property (!irq ##1 irq);
endmodule
`default_nettype wire

// ---- test/front_end_model.sv ----
/*
 * Converter front end model: presents a code and an overload level.
 * Assumes the block samples them within two cycles after integrating falls.
 */
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
    input  wire logic           clk,          // system clock
    input  wire logic           resetn,       // async reset, active low
    input  wire logic           integrating,  // period running
    input  wire lcs_pkg::range_t conv_range,  // range in use
    input  wire lcs_pkg::range_t ovl_below,   // overload at ranges below this
    input  wire logic [11:0]    level,        // code to present
    output logic [11:0]         adc_code,     // converted code
    output logic                adc_overload  // overload seen
);
    import lcs_pkg::*;
    logic [1:0] hold_ff;
    logic       win;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) hold_ff <= 2'h0;
        else hold_ff <= {hold_ff[0], integrating};
    end
    // outside the sample window show the inverse, never a stale value
    assign win          = integrating | (|hold_ff);
    assign adc_code     = win ? level : ~level;
    assign adc_overload = win ? (conv_range < ovl_below) : (conv_range >= ovl_below);
endmodule
`default_nettype wire

// ---- test/test_light_conv_ctrl.sv ----
/*
 * Self-checking bench of the conversion control block over AXI4-Lite.
 * Assumes a front end model on the converter side and shortened periods.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lcs_regs.svh"
module test_light_conv_ctrl;
    import lcs_pkg::*;
    logic        clk, resetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic        awready, wready, bvalid, arready, rvalid, integrating, integ_reset, irq;
    range_t      conv_range, ovl_below;
    logic [11:0] adc_code, level;
    logic        adc_overload;
    logic [15:0] cfg_row [5];
    logic [15:0] res_row [5];
    int          error_cnt, tests_run, pcnt, plen, nfall, f0, nstart, s0;
    light_conv_ctrl #(.SHORT_CYCLES(20), .LONG_CYCLES(50)) uut (
        .clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .integrating, .integ_reset, .conv_range, .adc_code, .adc_overload, .irq);
    front_end_model fe (.clk, .resetn, .integrating, .conv_range, .ovl_below, .level,
        .adc_code, .adc_overload);
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (integ_reset) nstart <= nstart + 1;
        if (integrating) pcnt <= pcnt + 1;
        else if (pcnt != 0) begin
            plen  <= pcnt;
            pcnt  <= 0;
            nfall <= nfall + 1;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        repeat (3) @(posedge clk);
        chk(irq, 1'b1);
    endtask
    task automatic shot(input logic [15:0] c);
        wr(`ISTAT_OFS, 32'h7);
        wr(`CFG_OFS, c);
        wait_irq;
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #400000;
        error_cnt++;
        close_out;
    end
    initial begin
        resetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hF;
        ovl_below = 4'h0; level = 12'hFFF; pcnt = 0; plen = 0; nfall = 0;
        error_cnt = 0; tests_run = 0; nstart = 0; s0 = 0;
        cfg_row = '{16'h5210, 16'h3210, 16'h0210, 16'h6210, 16'h0A10};
        res_row = '{16'h5FFE, 16'h3FFC, 16'h0FF8, 16'h6FFF, 16'h0FFF};
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rd(`CFG_OFS);
        chk(d, 32'h0000C810);
        chk(irq, 1'b0);
        rd(8'h40);
        chk(d, 32'h0);
        chk(r, `RESP_SLVERR);
        wr(8'h40, 32'h1);
        chk(r, `RESP_SLVERR);
        wr(`IMASK_OFS, 32'h1);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            shot(cfg_row[i]);
            rd(`CFG_OFS);
            chk(d[10:7], 4'h1);
            rd(`RES_OFS);
            chk(d, res_row[i]);
            chk(plen, cfg_row[i][11] ? 50 : 20);
        end
        $display("test table done");
        wr(`ISTAT_OFS, 32'h7);
        wr(`CFG_OFS, 32'h0A10);
        rd(`CFG_OFS);
        chk(d[10:7], 4'h4);
        wait_irq;
        wr(`CFG_OFS, 32'h0810);
        rd(`CFG_OFS);
        chk({d[10:7], irq}, 5'h03);
        rd(`CFG_OFS);
        chk(d[7], 1'b0);
        wr(`IMASK_OFS, 32'h0);
        chk(irq, 1'b0);
        wr(`IMASK_OFS, 32'h1);
        chk(irq, 1'b1);
        wr(`ISTAT_OFS, 32'h1);
        chk(irq, 1'b0);
        $display("test shutdown and interrupt done");
        wr(`ISTAT_OFS, 32'h7);
        f0 = nfall;
        s0 = nstart;
        wr(`CFG_OFS, 32'h0A10);
        repeat (10) @(posedge clk);
        wr(`CFG_OFS, 32'h0A10);
        wait_irq;
        chk(nfall - f0, 2);
        chk(plen, 50);
        chk(nstart - s0, 2);
        $display("test abort done");
        level = 12'h010;
        ovl_below = 4'h3;
        shot(16'h2210);
        rd(`CFG_OFS);
        chk(d[8], 1'b1);
        rd(`RES_OFS);
        chk(d, 32'h2010);
        ovl_below = 4'h0;
        shot(16'h2210);
        rd(`CFG_OFS);
        chk(d[8], 1'b0);
        ovl_below = 4'h3;
        shot(16'hC210);
        rd(`RES_OFS);
        chk(d, 32'h3010);
        rd(`CFG_OFS);
        chk({d[15:12], d[8]}, 5'h18);
        ovl_below = 4'hC;
        shot(16'hC210);
        rd(`RES_OFS);
        chk(d, 32'hB010);
        chk(conv_range, 4'hB);
        rd(`CFG_OFS);
        chk(d[8], 1'b1);
        $display("test overrange done");
        ovl_below = 4'h0;
        level = 12'h801;
        wr(`HLIM_OFS, 32'h0800);
        shot(16'h0C11);
        rd(`ISTAT_OFS);
        chk(d[`IRQ_ABOVE], 1'b0);
        wr(`ISTAT_OFS, 32'h7);
        wait_irq;
        rd(`ISTAT_OFS);
        chk(d[`IRQ_ABOVE], 1'b1);
        shot(16'h0A10);
        rd(`ISTAT_OFS);
        chk(d[`IRQ_ABOVE], 1'b1);
        wr(`CFG_OFS, 32'h0810);
        $display("test above limit done");
        close_out;
    end
endmodule
`default_nettype wire
